// file: core/mmos_mode_output.sv
// Mode control register and per-output function logic of the supply manager.
// Assumes the command decoder, sequencer, power-good, alarm and password
// logic all run on core_clk_i; no inputs here cross a clock domain.
`timescale 1ns/1ns

// Functional notes
// - Alert enable bit gates answers to ARA
// - Soft reset needs set-clear-set within window
// - Lock needs set-clear-set within window
// - Valid unlock clears the lock bit
// - Bits 7:6 choose conversion time 1-8us
// - Bits 5:4 choose averaging of 1-8 samples
// - Bits 3:0 give current depth 2^n samples
// - Unused mode bits always read zero
// - Twelve outputs each have own function field
// - Code 000 follows the sequencer enable
// - Codes 001/010 force asserted/deasserted
// - Code 011 ANDs enabled power-good inputs
// - Code 100 ORs enabled channel alarms
// - Bit 6 sets output polarity
// - Bit 7 selects push-pull or open-drain
module mmos_mode_output #(
   parameter int SEQ_WINDOW_CYCLES = mmos_pkg::SEQ_WINDOW_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic cmd_wr_i,
   input wire logic cmd_rd_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [7:0] cmd_page_i,
   input wire logic [31:0] cmd_wdata_i,
   input wire logic ara_request_i,
   input wire logic unlock_valid_i,
   input wire logic [11:0] seq_enable_i,
   input wire logic [15:0] power_good_flag_i,
   input wire logic [15:0] channel_alarm_i,
   output logic [31:0] rd_data_o,
   output logic rd_valid_o,
   output logic ara_ack_o,
   output logic soft_reset_o,
   output logic locked_o,
   output logic [1:0] conv_time_sel_o,
   output logic [3:0] conv_time_us_o,
   output logic [3:0] average_samples_o,
   output logic [15:0] current_average_depth_o,
   output logic [11:0] supply_enable_or_general_output_o,
   output logic [11:0] supply_enable_or_general_output_oe_o
);
   localparam int TW = 18;

   generate
      if (SEQ_WINDOW_CYCLES < 2 || SEQ_WINDOW_CYCLES > (2 ** TW) - 1) begin : g_bad
         $error("SEQ_WINDOW_CYCLES out of range");
      end
   endgenerate

   typedef enum logic [1:0] {
      MMOS_SEQ_IDLE = 2'b00,
      MMOS_SEQ_SET1 = 2'b01,
      MMOS_SEQ_CLEAR = 2'b10
   } mmos_seq_type;

   // ==========================================================
   // Register file
   logic [15:0] mode, next_mode;
   logic [31:0] cfg [12];
   logic [31:0] next_cfg [12];
   logic [31:0] next_rd_data;
   logic next_rd_valid, next_ara_ack, next_locked;
   logic [1:0] seq_fire;
   logic mode_wr;

   assign mode_wr = cmd_wr_i && cmd_code_i == mmos_pkg::CMD_DEVICE_MODE_CONTROL;

   always_comb begin
      next_mode = mode;
      if (mode_wr) begin
         next_mode = cmd_wdata_i[15:0] & mmos_pkg::MODE_WRITE_MASK;
      end
      if (unlock_valid_i) begin
         next_mode[mmos_pkg::MODE_LOCK_BIT] = 1'b0;
      end
      next_locked = locked_o;
      if (seq_fire[1]) begin
         next_locked = 1'b1;
      end
      if (unlock_valid_i) begin
         next_locked = 1'b0;
      end
      next_ara_ack = ara_request_i && mode[mmos_pkg::MODE_ALERT_BIT];
      next_rd_valid = cmd_rd_i;
      next_rd_data = 32'h0000_0000;
      if (cmd_rd_i && cmd_code_i == mmos_pkg::CMD_DEVICE_MODE_CONTROL) begin
         next_rd_data = {16'h0000, mode};
      end else if (cmd_rd_i && cmd_code_i == mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG
                   && cmd_page_i < 8'(mmos_pkg::NUM_OUTPUTS)) begin
         next_rd_data = cfg[cmd_page_i[3:0]];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         mode <= mmos_pkg::MODE_RESET;
         locked_o <= 1'b0;
         ara_ack_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= 32'h0000_0000;
      end else begin
         mode <= next_mode;
         locked_o <= next_locked;
         ara_ack_o <= next_ara_ack;
         rd_valid_o <= next_rd_valid;
         rd_data_o <= next_rd_data;
      end
   end

   // ==========================================================
   // Set-clear-set detectors: index 0 soft reset, index 1 lock
   // A stale partial sequence is dropped so a late third write starts afresh
   mmos_seq_type seq_state [2];
   mmos_seq_type next_seq_state [2];
   logic [TW-1:0] seq_timer [2];
   logic [TW-1:0] next_seq_timer [2];
   logic [1:0] next_seq_fire;

   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_seq
         localparam int BIT = (s == 0) ? mmos_pkg::MODE_SOFT_RESET_BIT
                                       : mmos_pkg::MODE_LOCK_BIT;
         logic wbit;
         logic expired;
         assign wbit = cmd_wdata_i[BIT];
         assign expired = seq_timer[s] >= TW'(SEQ_WINDOW_CYCLES - 1);

         always_comb begin
            next_seq_state[s] = seq_state[s];
            next_seq_timer[s] = seq_timer[s];
            next_seq_fire[s] = 1'b0;
            case (seq_state[s])
               MMOS_SEQ_IDLE: begin
                  if (mode_wr && wbit) begin
                     next_seq_state[s] = MMOS_SEQ_SET1;
                     next_seq_timer[s] = '0;
                  end
               end
               MMOS_SEQ_SET1, MMOS_SEQ_CLEAR: begin
                  next_seq_timer[s] = seq_timer[s] + TW'(1);
                  if (expired) begin
                     next_seq_state[s] = MMOS_SEQ_IDLE;
                  end else if (mode_wr && !wbit) begin
                     next_seq_state[s] = MMOS_SEQ_CLEAR;
                  end else if (mode_wr && wbit && seq_state[s] == MMOS_SEQ_CLEAR) begin
                     next_seq_state[s] = MMOS_SEQ_IDLE;
                     next_seq_fire[s] = 1'b1;
                  end
               end
               default: begin
                  next_seq_state[s] = MMOS_SEQ_IDLE;
               end
            endcase
         end

         always_ff @(posedge core_clk_i) begin
            if (!rst_b_i) begin
               seq_state[s] <= MMOS_SEQ_IDLE;
               seq_timer[s] <= '0;
            end else begin
               seq_state[s] <= next_seq_state[s];
               seq_timer[s] <= next_seq_timer[s];
            end
         end
      end
   endgenerate

   assign seq_fire = next_seq_fire;

   logic next_soft_reset;
   logic [3:0] next_conv_us, next_avg;
   logic [15:0] next_depth;

   always_comb begin
      next_soft_reset = seq_fire[0];
      next_conv_us = 4'(4'h1 << next_mode[mmos_pkg::MODE_CONV_TIME_LSB +: 2]);
      next_avg = 4'(4'h1 << next_mode[mmos_pkg::MODE_AVERAGE_LSB +: 2]);
      next_depth = 16'(17'h0_0001 << next_mode[mmos_pkg::MODE_CURRENT_DEPTH_LSB +: 4]);
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         soft_reset_o <= 1'b0;
         conv_time_sel_o <= 2'h0;
         conv_time_us_o <= 4'h1;
         average_samples_o <= 4'h1;
         current_average_depth_o <= 16'h0001;
      end else begin
         soft_reset_o <= next_soft_reset;
         conv_time_sel_o <= next_mode[mmos_pkg::MODE_CONV_TIME_LSB +: 2];
         conv_time_us_o <= next_conv_us;
         average_samples_o <= next_avg;
         current_average_depth_o <= next_depth;
      end
   end

   // ==========================================================
   // Per-output function logic
   // Reset value forces every pin deasserted until software picks a role
   genvar n;
   generate
      for (n = 0; n < mmos_pkg::NUM_OUTPUTS; n++) begin : g_pin
         logic [2:0] sel;
         logic [15:0] chan_mask;
         logic active, level, next_out, next_oe;
         assign sel = cfg[n][mmos_pkg::CFG_SELECT_LSB +: 3];
         assign chan_mask = cfg[n][mmos_pkg::CFG_MASK_LSB +: 16];

         always_comb begin
            next_cfg[n] = cfg[n];
            if (cmd_wr_i && cmd_code_i == mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG
                && cmd_page_i == 8'(n)) begin
               next_cfg[n] = cmd_wdata_i & mmos_pkg::CFG_WRITE_MASK;
            end
            case (sel)
               mmos_pkg::MMOS_FN_SEQUENCER: active = seq_enable_i[n];
               mmos_pkg::MMOS_FN_FORCE_ON: active = 1'b1;
               mmos_pkg::MMOS_FN_FORCE_OFF: active = 1'b0;
               mmos_pkg::MMOS_FN_POWER_GOOD_AND:
                  active = &(power_good_flag_i | ~chan_mask);
               mmos_pkg::MMOS_FN_ALARM_OR: active = |(channel_alarm_i & chan_mask);
               default: active = 1'b0;
            endcase
            // Polarity high means asserted drives a one
            level = cfg[n][mmos_pkg::CFG_POLARITY_BIT] ? active : !active;
            // Open drain only ever pulls low; the board supplies the high level
            next_out = cfg[n][mmos_pkg::CFG_DRIVE_BIT] ? 1'b0 : level;
            next_oe = cfg[n][mmos_pkg::CFG_DRIVE_BIT] ? !level : 1'b1;
         end

         always_ff @(posedge core_clk_i) begin
            if (!rst_b_i) begin
               cfg[n] <= mmos_pkg::CFG_RESET;
               supply_enable_or_general_output_o[n] <= 1'b1;
               supply_enable_or_general_output_oe_o[n] <= 1'b1;
            end else begin
               cfg[n] <= next_cfg[n];
               supply_enable_or_general_output_o[n] <= next_out;
               supply_enable_or_general_output_oe_o[n] <= next_oe;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Checks
   AST_ARA_ANSWER: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ara_request_i |=> (ara_ack_o == $past(mode[mmos_pkg::MODE_ALERT_BIT])))
      else $error("alert response does not follow enable bit");
   AST_SOFT_RESET_CAUSE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      soft_reset_o |-> $past(mode_wr) && $past(cmd_wdata_i[mmos_pkg::MODE_SOFT_RESET_BIT])
      && $past(seq_state[0]) == MMOS_SEQ_CLEAR)
      else $error("soft reset without completed sequence");
   AST_LOCK_SET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(locked_o) |-> $past(seq_state[1]) == MMOS_SEQ_CLEAR && $past(mode_wr))
      else $error("lock set without completed sequence");
   AST_UNLOCK_CLEARS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      unlock_valid_i |=> !locked_o && !mode[mmos_pkg::MODE_LOCK_BIT])
      else $error("unlock did not clear lock");
   AST_CONV_TIME: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      conv_time_us_o == 4'(4'h1 << conv_time_sel_o))
      else $error("conversion time does not match select");
   AST_DEPTH: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 current_average_depth_o == 16'(17'h0_0001 << $past(next_mode[3:0])))
      else $error("current average depth wrong");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      rd_valid_o && $past(cmd_code_i) == mmos_pkg::CMD_DEVICE_MODE_CONTROL
      |-> (rd_data_o & 32'hffff_d300) == 32'h0000_0000)
      else $error("reserved mode bits read nonzero");
   AST_WINDOW_DROP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      seq_state[0] != MMOS_SEQ_IDLE && seq_timer[0] >= TW'(SEQ_WINDOW_CYCLES - 1)
      |=> seq_state[0] == MMOS_SEQ_IDLE && !soft_reset_o)
      else $error("stale sequence not discarded");
   AST_FORCE_ON: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      cfg[0][2:0] == 3'h1 && cfg[0][7:6] == 2'h1 |=> supply_enable_or_general_output_o[0])
      else $error("forced output not asserted");
   AST_RESERVED_CODE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      cfg[0][2:0] >= 3'h5 && cfg[0][7:6] == 2'h1 |=> !supply_enable_or_general_output_o[0])
      else $error("reserved code drove output active");
   COV_SOFT_RESET: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) soft_reset_o);
   COV_LOCK_UNLOCK: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
      locked_o ##[1:50] !locked_o);
   COV_ARA: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) ara_ack_o);
endmodule

// file: common/mmos_pkg.sv
// Constants for the mode-control and output-function register block.
// Assumes a 20 MHz core clock and a PMBus front end that decodes commands.
package mmos_pkg;
   // ==========================================================
   // Command codes and pages
   localparam logic [7:0] CMD_DEVICE_MODE_CONTROL = 8'hd1;
   localparam logic [7:0] CMD_OUTPUT_PIN_FUNCTION_CONFIG = 8'hd2;
   localparam int NUM_OUTPUTS = 12;
   localparam int NUM_CHANNELS = 16;
   // ==========================================================
   // Mode register layout
   localparam int MODE_ALERT_BIT = 13;
   localparam int MODE_SOFT_RESET_BIT = 11;
   localparam int MODE_LOCK_BIT = 10;
   localparam int MODE_CONV_TIME_LSB = 6;
   localparam int MODE_AVERAGE_LSB = 4;
   localparam int MODE_CURRENT_DEPTH_LSB = 0;
   localparam logic [15:0] MODE_WRITE_MASK = 16'h2_cff;
   localparam logic [15:0] MODE_RESET = 16'h0_000;
   // ==========================================================
   // Output configuration layout
   localparam int CFG_MASK_LSB = 16;
   localparam int CFG_DRIVE_BIT = 7;
   localparam int CFG_POLARITY_BIT = 6;
   localparam int CFG_SELECT_LSB = 0;
   localparam logic [31:0] CFG_WRITE_MASK = 32'hffff_00c7;
   localparam logic [31:0] CFG_RESET = 32'h0000_0002;
   // ==========================================================
   // Function select codes
   typedef enum logic [2:0] {
      MMOS_FN_SEQUENCER = 3'h0,
      MMOS_FN_FORCE_ON = 3'h1,
      MMOS_FN_FORCE_OFF = 3'h2,
      MMOS_FN_POWER_GOOD_AND = 3'h3,
      MMOS_FN_ALARM_OR = 3'h4
   } mmos_fn_type;
   // ==========================================================
   // Set-clear-set window
   localparam longint CLK_PERIOD_NS = 50;
   localparam longint SEQ_WINDOW_NS = 8_000_000;
   localparam int SEQ_WINDOW_CYCLES = int'(SEQ_WINDOW_NS / CLK_PERIOD_NS);
endpackage

// file: tb/mmos_host_model.sv
// Host model: issues command writes and reads on the block's command port.
// Assumes the block samples its strobes on the rising edge of clk_i.
`timescale 1ns/1ns
module mmos_host_model (
   input wire logic clk_i,
   input wire logic rd_valid_i,
   input wire logic [31:0] rd_data_i,
   output logic cmd_wr_o,
   output logic cmd_rd_o,
   output logic [7:0] cmd_code_o,
   output logic [7:0] cmd_page_o,
   output logic [31:0] cmd_wdata_o
);
   // ==========================================================
   // Command tasks
   // Supplies stay idle while outputs change, and lock cycles are few
   // Channel setup lives outside this block, so it is not driven here
   initial begin
      cmd_wr_o = 1'b0;
      cmd_rd_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_page_o = 8'h00;
      cmd_wdata_o = 32'h0000_0000;
   end
   task automatic op(input logic wr, input logic [7:0] code, input logic [7:0] page,
         input logic [31:0] data);
      @(negedge clk_i);
      cmd_wr_o = wr;
      cmd_rd_o = !wr;
      cmd_code_o = code;
      cmd_page_o = page;
      cmd_wdata_o = data;
      @(negedge clk_i);
      cmd_wr_o = 1'b0;
      cmd_rd_o = 1'b0;
      // Released lines flip so a stale value is never mistaken for a request
      cmd_code_o = ~code;
      cmd_page_o = ~page;
      cmd_wdata_o = ~data;
   endtask
   task automatic rd(input logic [7:0] code, input logic [7:0] page, output logic [31:0] d);
      op(1'b0, code, page, 32'h0000_0000);
      d = (rd_valid_i === 1'b1) ? rd_data_i : 'x;
   endtask
endmodule

// file: tb/monitor_mode_and_output_select_tb.sv
// Self-checking bench for the mode-control and output-function block.
// Assumes the host model drives the command port; other inputs set here.
`timescale 1ns/1ns
module monitor_mode_and_output_select_tb;
   typedef struct {logic [31:0] cfg; logic seq; logic [15:0] pg; logic [15:0] al;
      logic [1:0] pin;} mmos_row_type;
   logic core_clk_i = 1'b0, rst_b_i = 1'b0, ara_request_i = 1'b0, unlock_valid_i = 1'b0;
   logic [11:0] seq_enable_i = 12'h000;
   logic [15:0] power_good_flag_i = 16'h0000, channel_alarm_i = 16'h0000;
   logic cmd_wr_i, cmd_rd_i, rd_valid_o, ara_ack_o, soft_reset_o, locked_o;
   logic [7:0] cmd_code_i, cmd_page_i;
   logic [31:0] cmd_wdata_i, rd_data_o, d;
   logic [1:0] conv_time_sel_o;
   logic [3:0] conv_time_us_o, average_samples_o;
   logic [15:0] current_average_depth_o, m;
   logic [11:0] pins, pins_oe;
   int num_errors = 0, checks = 0, cycles = 0, n_rst = 0, n_ack = 0;
   mmos_row_type rows [12] = '{
      '{32'h0000_0040, 1, 0, 0, 2'b11}, '{32'h0000_0040, 0, 0, 0, 2'b01},
      '{32'h0000_0041, 0, 0, 0, 2'b11}, '{32'h0000_0042, 0, 0, 0, 2'b01},
      '{32'h0003_0043, 0, 16'h0003, 0, 2'b11}, '{32'h0003_0043, 0, 16'h0001, 0, 2'b01},
      '{32'h0004_0044, 0, 0, 16'h0004, 2'b11}, '{32'h0004_0044, 0, 0, 16'h0003, 2'b01},
      '{32'h0000_0046, 1, 0, 0, 2'b01}, '{32'h0000_0001, 0, 0, 0, 2'b01},
      '{32'h0000_00c1, 0, 0, 0, 2'b00}, '{32'h0000_00c2, 0, 0, 0, 2'b01}};
   mmos_mode_output #(.SEQ_WINDOW_CYCLES(20)) u_mmos_mode_output (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
      .cmd_page_i(cmd_page_i), .cmd_wdata_i(cmd_wdata_i), .ara_request_i(ara_request_i),
      .unlock_valid_i(unlock_valid_i), .seq_enable_i(seq_enable_i),
      .power_good_flag_i(power_good_flag_i), .channel_alarm_i(channel_alarm_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .ara_ack_o(ara_ack_o),
      .soft_reset_o(soft_reset_o), .locked_o(locked_o), .conv_time_sel_o(conv_time_sel_o),
      .conv_time_us_o(conv_time_us_o), .average_samples_o(average_samples_o),
      .current_average_depth_o(current_average_depth_o),
      .supply_enable_or_general_output_o(pins),
      .supply_enable_or_general_output_oe_o(pins_oe));
   mmos_host_model u_mmos_host_model (.clk_i(core_clk_i), .rd_valid_i(rd_valid_o),
      .rd_data_i(rd_data_o), .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i),
      .cmd_code_o(cmd_code_i), .cmd_page_o(cmd_page_i), .cmd_wdata_o(cmd_wdata_i));
   // ==========================================================
   // Clock, pulse counters and watchdog
   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      n_rst <= n_rst + int'(soft_reset_o === 1'b1);
      n_ack <= n_ack + int'(ara_ack_o === 1'b1);
      if (cycles == 6000) begin
         num_errors = num_errors + 1;
         final_report();
      end
   end
   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wm(input logic [15:0] v);
      u_mmos_host_model.op(1'b1, mmos_pkg::CMD_DEVICE_MODE_CONTROL, 8'h00, {16'h0000, v});
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      wait_cyc(6);
      rst_b_i = 1'b1;
      check({pins, pins_oe, locked_o}, {12'hfff, 12'hfff, 1'b0});
      check(current_average_depth_o, 32'h0000_0001);
      foreach (rows[i]) begin
         seq_enable_i = {11'h000, rows[i].seq};
         power_good_flag_i = rows[i].pg;
         channel_alarm_i = rows[i].al;
         u_mmos_host_model.op(1'b1, mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'h00, rows[i].cfg);
         wait_cyc(3);
         check({pins[0], pins_oe[0]}, rows[i].pin);
         u_mmos_host_model.rd(mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'h00, d);
         check(d, rows[i].cfg & mmos_pkg::CFG_WRITE_MASK);
      end
      // Field decode, with every reserved bit written as one
      for (int i = 0; i < 16; i++) begin
         m = 16'hd300 | 16'(i[1:0] << 6) | 16'(i[1:0] << 4) | 16'(i);
         wm(m);
         wait_cyc(2);
         check(conv_time_us_o, 32'(1 << i[1:0]));
         check(conv_time_sel_o, 32'(i[1:0]));
         check(average_samples_o, 32'(1 << i[1:0]));
         check(current_average_depth_o, 32'(1 << i));
         u_mmos_host_model.rd(mmos_pkg::CMD_DEVICE_MODE_CONTROL, 8'h00, d);
         check(d, {16'h0000, m & 16'h00ff});
      end
      // Outputs are independent; a page beyond the last is ignored
      u_mmos_host_model.op(1'b1, mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'd11, 32'h0000_0041);
      u_mmos_host_model.op(1'b1, mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'd12, 32'h0000_0041);
      wait_cyc(3);
      check({pins[11], pins[10], pins[0]}, 32'h0000_0006);
      u_mmos_host_model.rd(mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'd12, d);
      check(d, 32'h0000_0000);
      // Alert response only while enabled
      for (int i = 0; i < 2; i++) begin
         wm(i[0] ? 16'h2000 : 16'h0000);
         n_ack = 0;
         ara_request_i = 1'b1;
         wait_cyc(1);
         ara_request_i = 1'b0;
         wait_cyc(3);
         check(n_ack, 32'(i));
      end
      // Set-clear-set in time fires once; a late third write fires no reset
      n_rst = 0;
      wm(16'h0800);
      wm(16'h0000);
      wm(16'h0800);
      wait_cyc(3);
      check(n_rst, 32'h0000_0001);
      wm(16'h0000);
      wm(16'h0800);
      wm(16'h0000);
      wait_cyc(22);
      wm(16'h0800);
      wait_cyc(25);
      check(n_rst, 32'h0000_0001);
      // Lock by sequence, unlock clears bit and state
      wm(16'h0400);
      wm(16'h0000);
      wm(16'h0400);
      wait_cyc(2);
      check(locked_o, 32'h0000_0001);
      unlock_valid_i = 1'b1;
      wait_cyc(1);
      unlock_valid_i = 1'b0;
      wait_cyc(2);
      u_mmos_host_model.rd(mmos_pkg::CMD_DEVICE_MODE_CONTROL, 8'h00, d);
      check({d[10], locked_o}, 32'h0000_0000);
      // Reset in mid-run returns every pin to its forced-off level
      rst_b_i = 1'b0;
      wait_cyc(2);
      rst_b_i = 1'b1;
      check({pins, pins_oe, locked_o}, {12'hfff, 12'hfff, 1'b0});
      u_mmos_host_model.rd(mmos_pkg::CMD_OUTPUT_PIN_FUNCTION_CONFIG, 8'h00, d);
      check(d, mmos_pkg::CFG_RESET);
      final_report();
   end
endmodule
